// [sic_config_regs.sv]
// global settings and high-impedance control registers behind an spi frame port
// Overview of operation
// R1 - fault flag sets on any fault, clears on fault-status read once faults gone
// R2 - interrupt flag sets on any event, clears on any transaction to a holder
// R3 - poll length bit: 0 gives 1.0 ms window, 1 gives 55 us; reset 0
// R4 - wake qualify 0: wake pin ignored in low power when logic rail low
// R5 - wake qualify 1 (reset): falling wake edge wakes regardless of rail
// R6 - interrupt style 0 latches pin low, 1 pulses low then returns high
// R7 - mux field: 00/01 spi control, 10 hardwired 2-bit, 11 hardwired 3-bit
// R8 - twelve polarity bits: 0 to ground, 1 to battery; all reset to 1
// R9 - high-impedance bit set floats input and overrides wetting current
// R10 - input comparator stays on while input floats; threshold 4.0 V default
// R11 - host may rewrite high-impedance register any time in normal mode
// R12 - all twelve high-impedance bits reset to 1
// R13 - floating inputs still polled in low power with source off
// R14 - change of state and wake decided at end of active poll window
// R15 - overvoltage with disable 0 limits currents to 2 mA, blocks low power
// R16 - changing a polarity bit raises an interrupt
// R17 - closed switch reports 1 whatever the polarity
// R18 - 32-bit frame: address 31:25, write 24, data 23:0, flags on top
// R19 - unused bits ignore writes and read zero
`timescale 1ns/1ns
`default_nettype none
module sic_config_regs
(
  // clock and reset
  input  wire logic                         CLK_IN,
  input  wire logic                         RESETN_IN,
  // spi pins
  input  wire logic                         SCLK_IN,
  input  wire logic                         CSN_IN,
  input  wire logic                         MOSI_IN,
  output logic                              MISO_OUT,
  // analog and status pins
  input  wire logic                         FAULT_EVENT_IN,
  input  wire logic                         FAULT_PRESENT_IN,
  input  wire logic                         OVERVOLTAGE_IN,
  input  wire logic                         LOGIC_SUPPLY_RAIL_IN,
  input  wire logic                         WAKEN_IN,
  input  wire logic                         LOW_POWER_MODE_IN,
  input  wire logic [sic_pkg::NUM_INPUTS-1:0] COMPARATOR_IN,
  // control outputs
  output logic                              INTN_OUT,
  output logic                              WAKE_OUT,
  output logic                              LOW_POWER_ALLOWED_OUT,
  output logic                              CURRENT_LIMIT_2MA_OUT,
  output logic      [1:0]                   ANALOG_MUX_OUTPUT_MODE_OUT,
  output logic [sic_pkg::NUM_INPUTS-1:0]    TO_BATTERY_SENSING_OUT,
  output logic [sic_pkg::NUM_INPUTS-1:0]    HIGH_Z_OUT,
  output logic [sic_pkg::NUM_INPUTS-1:0]    SOURCE_ENABLE_OUT,
  output logic [sic_pkg::NUM_INPUTS-1:0]    COMPARATOR_ENABLE_OUT,
  output logic [sic_pkg::NUM_INPUTS-1:0]    SWITCH_CLOSED_OUT
);
  import sic_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic [21:0]           global_q;
  logic [11:0]           high_z_q;
  logic                  fault_flag_q, int_flag_q;
  logic [31:0]           rx_word, tx_word;
  logic                  frame_start, frame_done;
  logic [6:0]            addr, last_addr_q;
  logic [23:0]           wdata;
  logic                  wr, holder, pol_change, sw_event, int_event, active_poll;
  logic [1:0]            ov_s_q, rail_s_q, lpm_s_q, flt_s_q, fltp_s_q;
  logic [2:0]            wake_s_q;
  logic [NUM_INPUTS-1:0] cmp_s1_q, cmp_s2_q;
  logic [NUM_INPUTS-1:0] closed_q, closed_d, lpm_ref_q;
  sic_poll_type          poll_q;
  logic [17:0]           poll_cnt_q;
  logic [6:0]            pulse_cnt_q;

  // ****************************************************************
  // frame port
  // ****************************************************************
  sic_spi_frame u_frame
  (
    .clk_in          (CLK_IN),
    .resetn_in       (RESETN_IN),
    .sclk_in         (SCLK_IN),
    .csn_in          (CSN_IN),
    .mosi_in         (MOSI_IN),
    .miso_out        (MISO_OUT),
    .tx_word_in      (tx_word),
    .rx_word_out     (rx_word),
    .frame_start_out (frame_start),
    .frame_done_out  (frame_done)
  );

  // decode the received frame
  assign addr   = rx_word[ADDR_MSB:ADDR_LSB];                       // R18
  assign wr     = rx_word[WRITE_BIT];                               // R18
  assign wdata  = rx_word[23:0];
  assign holder = (addr == ADDR_GLOBAL_SETTINGS) || (addr == ADDR_HIGH_IMPEDANCE);
  // answer word loaded at frame start holds flags and the previously addressed register
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
      last_addr_q <= 7'h0;
    else if (frame_done)
      last_addr_q <= addr;
  end
  always_comb
  begin
    tx_word = 32'h0;
    tx_word[FAULT_BIT]   = fault_flag_q;                            // R18
    tx_word[INTFLAG_BIT] = int_flag_q;
    if (last_addr_q == ADDR_GLOBAL_SETTINGS)
      tx_word[21:0] = global_q & GLOBAL_MASK;                       // R19
    else if (last_addr_q == ADDR_HIGH_IMPEDANCE)
      tx_word[21:0] = {10'h0, high_z_q};                            // R19
  end

  // ****************************************************************
  // synchronisers for pins
  // ****************************************************************
  always_ff @(posedge CLK_IN)
  begin
    ov_s_q   <= {ov_s_q[0], OVERVOLTAGE_IN};
    rail_s_q <= {rail_s_q[0], LOGIC_SUPPLY_RAIL_IN};
    wake_s_q <= {wake_s_q[1:0], WAKEN_IN};
    lpm_s_q  <= {lpm_s_q[0], LOW_POWER_MODE_IN};
    flt_s_q  <= {flt_s_q[0], FAULT_EVENT_IN};
    fltp_s_q <= {fltp_s_q[0], FAULT_PRESENT_IN};
    cmp_s1_q <= COMPARATOR_IN;
    cmp_s2_q <= cmp_s1_q;
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      global_q <= GLOBAL_RESET;                                     // R3 R5 R6 R7 R8
      high_z_q <= HIGH_Z_RESET;                                     // R12
    end
    else if (frame_done && wr && !lpm_s_q[1])
    begin
      if (addr == ADDR_GLOBAL_SETTINGS)
        global_q <= wdata[21:0] & GLOBAL_MASK;                      // R19
      if (addr == ADDR_HIGH_IMPEDANCE)
        high_z_q <= wdata[11:0];                                    // R11 R19
    end
  end
  assign pol_change = frame_done && wr && !lpm_s_q[1] && (addr == ADDR_GLOBAL_SETTINGS)
                      && (wdata[11:0] != global_q[11:0]);           // R16

  // ****************************************************************
  // switch state and polling
  // ****************************************************************
  // closed switch reads 1: comparator high means to-ground switch closed by design choice
  assign closed_d = cmp_s2_q ^ global_q[NUM_INPUTS-1:0];                // R17
  assign active_poll = (poll_q == POLL_ACTIVE);
  // low power poll cycle: wait, active window, evaluate at its end
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN || !lpm_s_q[1])
    begin
      poll_q     <= POLL_IDLE;
      poll_cnt_q <= 18'h0;
    end
    else
    begin
      case (poll_q)
        POLL_IDLE:
        begin
          poll_cnt_q <= poll_cnt_q + 18'h1;
          if (poll_cnt_q == 18'(POLL_PERIOD_CYC - 1))
          begin
            poll_cnt_q <= 18'h0;
            poll_q     <= POLL_ACTIVE;
          end
        end
        POLL_ACTIVE:
        begin
          poll_cnt_q <= poll_cnt_q + 18'h1;
          if (poll_cnt_q == (global_q[POLL_LENGTH_BIT] ? 18'(POLL_SHORT_CYC - 1)
                                                       : 18'(POLL_LONG_CYC - 1)))
          begin
            poll_cnt_q <= 18'h0;
            poll_q     <= POLL_EVAL;                                // R3 R14
          end
        end
        default:
          poll_q <= POLL_IDLE;                                      // evaluation lasts one cycle
      endcase
    end
  end
  // switch state tracking and wake decision
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      closed_q  <= closed_d;                                        // no false change at release
      lpm_ref_q <= closed_d;
      WAKE_OUT  <= 1'b0;
    end
    else
    begin
      closed_q <= closed_d;
      WAKE_OUT <= 1'b0;
      if (!lpm_s_q[1])
        lpm_ref_q <= closed_d;
      else if (poll_q == POLL_EVAL)
      begin
        lpm_ref_q <= closed_d;
        if (closed_d != lpm_ref_q)
          WAKE_OUT <= 1'b1;                                         // R14
      end
      if (lpm_s_q[1] && !wake_s_q[1] && wake_s_q[2]
          && (global_q[WAKE_QUAL_BIT] || rail_s_q[1]))
        WAKE_OUT <= 1'b1;                                           // R4 R5
    end
  end
  assign sw_event  = !lpm_s_q[1] && (closed_d != closed_q);
  assign int_event = sw_event || pol_change;

  // ****************************************************************
  // global flags
  // ****************************************************************
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      fault_flag_q <= 1'b0;
      int_flag_q   <= 1'b0;
    end
    else
    begin
      if (flt_s_q[1] || fltp_s_q[1])
        fault_flag_q <= 1'b1;                                       // R1
      else if (frame_done && addr == ADDR_FAULT_STATUS)
        fault_flag_q <= 1'b0;                                       // R1
      if (int_event)
        int_flag_q <= 1'b1;                                         // R2
      else if (frame_done && holder)
        int_flag_q <= 1'b0;                                         // R2
    end
  end

  // interrupt pin: latch low or pulse low
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      INTN_OUT    <= 1'b1;
      pulse_cnt_q <= 7'h0;
    end
    else if (int_event)
    begin
      INTN_OUT    <= 1'b0;
      pulse_cnt_q <= 7'(INT_PULSE_CYC);
    end
    else if (global_q[INT_STYLE_BIT])
    begin
      if (pulse_cnt_q != 7'h0)
        pulse_cnt_q <= pulse_cnt_q - 7'h1;
      else
        INTN_OUT <= 1'b1;                                           // R6
    end
    else if (frame_done && holder)
      INTN_OUT <= 1'b1;                                             // R6
  end

  // ****************************************************************
  // control outputs
  // ****************************************************************
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      LOW_POWER_ALLOWED_OUT      <= 1'b1;
      CURRENT_LIMIT_2MA_OUT      <= 1'b0;
      ANALOG_MUX_OUTPUT_MODE_OUT <= MUX_SPI_A;
      TO_BATTERY_SENSING_OUT     <= 12'hFFF;
      HIGH_Z_OUT                 <= HIGH_Z_RESET;
      SOURCE_ENABLE_OUT          <= 12'h0;
      COMPARATOR_ENABLE_OUT      <= 12'hFFF;
      SWITCH_CLOSED_OUT          <= 12'h0;
    end
    else
    begin
      CURRENT_LIMIT_2MA_OUT      <= ov_s_q[1] && !global_q[OV_DISABLE_BIT];   // R15
      LOW_POWER_ALLOWED_OUT      <= !(ov_s_q[1] && !global_q[OV_DISABLE_BIT]); // R15
      ANALOG_MUX_OUTPUT_MODE_OUT <= global_q[MUX_CFG_MSB:MUX_CFG_LSB];         // R7
      TO_BATTERY_SENSING_OUT     <= global_q[NUM_INPUTS-1:0];                  // R8
      HIGH_Z_OUT                 <= high_z_q;                                  // R9
      COMPARATOR_ENABLE_OUT      <= 12'hFFF;                                   // R10
      SOURCE_ENABLE_OUT          <= ~high_z_q & {NUM_INPUTS{!lpm_s_q[1] || active_poll}}; // R9 R13
      SWITCH_CLOSED_OUT          <= closed_q;                                  // R17
    end
  end
endmodule // sic_config_regs
`default_nettype wire

// [sic_pkg.sv]
// package of constants and types for the switch input configuration block
package sic_pkg;
  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam int FRAME_BITS   = 32;
  localparam int ADDR_MSB     = 31;
  localparam int ADDR_LSB     = 25;
  localparam int WRITE_BIT    = 24;
  localparam int FAULT_BIT    = 23;
  localparam int INTFLAG_BIT  = 22;
  // ****************************************************************
  // register addresses and fields
  // ****************************************************************
  localparam logic [6:0] ADDR_GLOBAL_SETTINGS = 7'h01;
  localparam logic [6:0] ADDR_HIGH_IMPEDANCE  = 7'h02;
  localparam logic [6:0] ADDR_FAULT_STATUS    = 7'h21;
  localparam int POLL_LENGTH_BIT = 17;
  localparam int OV_DISABLE_BIT  = 16;
  localparam int WAKE_QUAL_BIT   = 15;
  localparam int INT_STYLE_BIT   = 14;
  localparam int MUX_CFG_MSB     = 13;
  localparam int MUX_CFG_LSB     = 12;
  localparam int NUM_INPUTS      = 12;
  localparam logic [21:0] GLOBAL_RESET   = 22'h008FFF;
  localparam logic [21:0] GLOBAL_MASK    = 22'h03FFFF;
  localparam logic [11:0] HIGH_Z_RESET   = 12'hFFF;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ        = 50000000;
  localparam int POLL_LONG_US  = 1000;
  localparam int POLL_SHORT_NS = 55000;
  localparam int POLL_LONG_CYC  = POLL_LONG_US * (CLK_HZ / 1000000);
  localparam int POLL_SHORT_CYC = POLL_SHORT_NS / (1000000000 / CLK_HZ);
  localparam int INT_PULSE_CYC  = 50;
  localparam int POLL_PERIOD_CYC = 250000;
  // ****************************************************************
  // analog mux control codes and poll states
  // ****************************************************************
  typedef enum logic [1:0]
  {
    MUX_SPI_A = 2'h0,
    MUX_SPI_B = 2'h1,
    MUX_HW2   = 2'h2,
    MUX_HW3   = 2'h3
  } sic_mux_type;
  typedef enum logic [1:0]
  {
    POLL_IDLE   = 2'h0,
    POLL_ACTIVE = 2'h1,
    POLL_EVAL   = 2'h3
  } sic_poll_type;
endpackage

// [sic_spi_frame.sv]
// spi slave that shifts a 32-bit frame in and out
`timescale 1ns/1ns
`default_nettype none
module sic_spi_frame
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // spi pins, synchronised inside this module
  input  wire logic        sclk_in,
  input  wire logic        csn_in,
  input  wire logic        mosi_in,
  output logic             miso_out,
  // frame side
  input  wire logic [31:0] tx_word_in,
  output logic      [31:0] rx_word_out,
  output logic             frame_start_out,
  output logic             frame_done_out
);
  logic [2:0]  sclk_s_q;
  logic [2:0]  csn_s_q;
  logic [1:0]  mosi_s_q;
  logic [31:0] shift_q;
  logic [31:0] out_q;
  logic        rise;
  logic        fall;
  logic        cs_fall;
  logic        cs_rise;

  // two-flop synchronisers plus one history stage for edges
  always_ff @(posedge clk_in)
  begin
    sclk_s_q <= {sclk_s_q[1:0], sclk_in};
    csn_s_q  <= {csn_s_q[1:0], csn_in};
    mosi_s_q <= {mosi_s_q[0], mosi_in};
  end

  assign rise    = sclk_s_q[1] & ~sclk_s_q[2];
  assign fall    = ~sclk_s_q[1] & sclk_s_q[2];
  assign cs_fall = ~csn_s_q[1] & csn_s_q[2];
  assign cs_rise = csn_s_q[1] & ~csn_s_q[2];

  // sample on rising clock edge, change output on falling edge
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      shift_q         <= 32'h0;
      out_q           <= 32'h0;
      rx_word_out     <= 32'h0;
      frame_start_out <= 1'b0;
      frame_done_out  <= 1'b0;
      miso_out        <= 1'b0;
    end
    else
    begin
      frame_start_out <= cs_fall;
      frame_done_out  <= cs_rise;
      if (cs_fall)
      begin
        out_q    <= {tx_word_in[30:0], 1'b0};
        miso_out <= tx_word_in[31];
      end
      else if (!csn_s_q[1] && fall)
      begin
        miso_out <= out_q[31];
        out_q    <= {out_q[30:0], 1'b0};
      end
      if (!csn_s_q[1] && rise)
        shift_q <= {shift_q[30:0], mosi_s_q[1]};
      if (cs_rise)
        rx_word_out <= shift_q;
    end
  end
endmodule // sic_spi_frame
`default_nettype wire

// [sic_config_regs_sva.sv]
// checker on the top-level ports of the configuration block
`timescale 1ns/1ns
`default_nettype none
module sic_cfg_sva
(
  // clock and reset
  input wire logic        CLK_IN,
  input wire logic        RESETN_IN,
  // watched inputs
  input wire logic        CSN_IN,
  input wire logic        OVERVOLTAGE_IN,
  input wire logic        LOW_POWER_MODE_IN,
  input wire logic [11:0] COMPARATOR_IN,
  // watched outputs
  input wire logic        INTN_OUT,
  input wire logic        WAKE_OUT,
  input wire logic        LOW_POWER_ALLOWED_OUT,
  input wire logic        CURRENT_LIMIT_2MA_OUT,
  input wire logic [11:0] TO_BATTERY_SENSING_OUT,
  input wire logic [11:0] HIGH_Z_OUT,
  input wire logic [11:0] SOURCE_ENABLE_OUT,
  input wire logic [11:0] COMPARATOR_ENABLE_OUT,
  input wire logic [11:0] SWITCH_CLOSED_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // ****************
  // port relations
  // ****************
  a_cmp_stays_on: assert property (COMPARATOR_ENABLE_OUT == 12'hFFF)
    else $error("comparator enable dropped");
  a_src_off_highz: assert property ((SOURCE_ENABLE_OUT & HIGH_Z_OUT) == 12'h000)
    else $error("source on for a floating input");
  a_limit_blocks_lpm: assert property (CURRENT_LIMIT_2MA_OUT |-> !LOW_POWER_ALLOWED_OUT)
    else $error("low power allowed while limited");
  a_no_ov_normal: assert property ((!OVERVOLTAGE_IN) [*6] |-> !CURRENT_LIMIT_2MA_OUT && LOW_POWER_ALLOWED_OUT)
    else $error("limit without overvoltage");
  a_closed_report: assert property ((RESETN_IN && $stable(COMPARATOR_IN)
    && $stable(TO_BATTERY_SENSING_OUT)) [*6] |-> SWITCH_CLOSED_OUT == (COMPARATOR_IN ^ TO_BATTERY_SENSING_OUT))
    else $error("switch closed report wrong");
  a_wake_one_cycle: assert property (WAKE_OUT |=> !WAKE_OUT)
    else $error("wake longer than a cycle");
  a_pol_raises_int: assert property ($changed(TO_BATTERY_SENSING_OUT) |-> ##[0:3] !INTN_OUT)
    else $error("polarity change without interrupt");
  a_cfg_after_frame: assert property (($changed(HIGH_Z_OUT) || $changed(TO_BATTERY_SENSING_OUT))
    |-> CSN_IN && !LOW_POWER_MODE_IN)
    else $error("config changed outside a normal mode frame end");
endmodule // sic_cfg_sva
`default_nettype wire

// [sic_host_model.sv]
// spi master model standing for the host controller
`timescale 1ns/1ns
`default_nettype none
module sic_host_model
(
  // clock and serial answer
  input  wire logic clk_in,
  input  wire logic miso_in,
  // serial request pins
  output var logic  sclk_out,
  output var logic  csn_out,
  output var logic  mosi_out
);
  // idle pins: clock low, not selected
  initial
  begin
    sclk_out = 1'b0;
    csn_out = 1'b1;
    mosi_out = 1'b0;
  end
  // one full-duplex 32-bit frame, msb first, pins move on falling clock edges
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    @(negedge clk_in) csn_out = 1'b0;
    repeat (4) @(negedge clk_in);
    for (int i = 31; i >= 0; i--)
    begin
      mosi_out = tx[i];
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      rx[i] = miso_in;
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    csn_out = 1'b1;
    mosi_out = ~mosi_out; // released line shows no stale bit
    repeat (10) @(negedge clk_in);
  endtask
endmodule // sic_host_model
`default_nettype wire

// [sic_config_regs_tb_top.sv]
// self-checking bench for the configuration register block
`timescale 1ns/1ns
`default_nettype none
module sic_config_regs_tb_top;
  import sic_pkg::*;
  logic clk, rst_n, sclk, csn, mosi, miso, fev, fpr, ov, rail, waken, low_power_mode;
  logic intn, wake, lpa, lim;
  logic [1:0] mux;
  logic [11:0] cmp, pol, hz, src, cen, cls, hzm;
  logic [21:0] gl;
  logic [6:0] prv;
  logic fm, im;
  int n_mismatch, cmp_count, n_wake, cyc;
  // design and host model
  sic_config_regs sic_config_regs_i (.CLK_IN(clk), .RESETN_IN(rst_n), .SCLK_IN(sclk), .CSN_IN(csn),
    .MOSI_IN(mosi), .MISO_OUT(miso), .FAULT_EVENT_IN(fev), .FAULT_PRESENT_IN(fpr), .OVERVOLTAGE_IN(ov),
    .LOGIC_SUPPLY_RAIL_IN(rail), .WAKEN_IN(waken), .LOW_POWER_MODE_IN(low_power_mode), .COMPARATOR_IN(cmp),
    .INTN_OUT(intn), .WAKE_OUT(wake), .LOW_POWER_ALLOWED_OUT(lpa), .CURRENT_LIMIT_2MA_OUT(lim),
    .ANALOG_MUX_OUTPUT_MODE_OUT(mux), .TO_BATTERY_SENSING_OUT(pol), .HIGH_Z_OUT(hz),
    .SOURCE_ENABLE_OUT(src), .COMPARATOR_ENABLE_OUT(cen), .SWITCH_CLOSED_OUT(cls));
  sic_host_model sic_host_model_i (.clk_in(clk), .miso_in(miso), .sclk_out(sclk), .csn_out(csn),
    .mosi_out(mosi));
  // clock at 50 mhz
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // wake pulse counter and hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (wake === 1'b1) n_wake++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ****************
  // shared tasks
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // frame with answer check, model update and output check
  task automatic xfer(input logic [6:0] a, input logic w, input logic [23:0] d);
    logic [31:0] rx;
    logic [21:0] e;
    e = (prv == ADDR_GLOBAL_SETTINGS) ? gl : (prv == ADDR_HIGH_IMPEDANCE) ? {10'h000, hzm} : 22'h0;
    sic_host_model_i.frame({a, w, d}, rx);
    check(rx[21:0], e);
    check(rx[23:22], {fm, im});
    prv = a;
    if (a == ADDR_GLOBAL_SETTINGS || a == ADDR_HIGH_IMPEDANCE) im = 1'b0;
    if (a == ADDR_FAULT_STATUS && !fpr) fm = 1'b0;
    if (w && !low_power_mode && a == ADDR_GLOBAL_SETTINGS)
    begin
      if (d[11:0] != gl[11:0]) im = 1'b1;
      gl = d[21:0] & GLOBAL_MASK;
    end
    if (w && !low_power_mode && a == ADDR_HIGH_IMPEDANCE) hzm = d[11:0];
    repeat (6) @(negedge clk);
    check(pol, gl[11:0]);
    check(hz, hzm);
    check(mux, gl[13:12]);
    check(src, low_power_mode ? 12'h000 : 12'(~hzm));
    check(cen, 12'hFFF);
    if (!gl[14]) check(intn, !im);
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    {rst_n, fev, fpr, ov, low_power_mode} = 5'h00;
    {rail, waken} = 2'h3;
    cmp = 12'h000;
    gl = GLOBAL_RESET;
    hzm = HIGH_Z_RESET;
    {prv, fm, im} = 9'h000;
    void'($urandom(17));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check({lim, lpa, intn, wake}, 4'h6);
    check({mux, pol, hz}, {2'h0, 12'hFFF, 12'hFFF});
    // reset values, unmapped write and zero answer
    xfer(ADDR_GLOBAL_SETTINGS, 1'b0, 24'h0);
    xfer(ADDR_HIGH_IMPEDANCE, 1'b0, 24'h0);
    xfer(7'h05, 1'b1, 24'hFFFFFF);
    xfer(ADDR_GLOBAL_SETTINGS, 1'b0, 24'h0);
    // every mux code, unused bits set
    for (int m = 0; m < 4; m++) xfer(ADDR_GLOBAL_SETTINGS, 1'b1, {8'h3C, 2'b10, m[1:0], 12'hFFF});
    // random traffic with latching interrupt style
    for (int k = 0; k < 8; k++)
      xfer(7'($urandom_range(2, 1)), 1'($urandom), 24'($urandom) & 24'hFFBFFF);
    // switch change raises the flag
    cmp = 12'($urandom) | 12'h001;
    repeat (8) @(negedge clk);
    im = 1'b1;
    check(cls, cmp ^ pol);
    check(intn, 1'b0);
    xfer(ADDR_GLOBAL_SETTINGS, 1'b0, 24'h0);
    // pulsed interrupt style
    xfer(ADDR_GLOBAL_SETTINGS, 1'b1, {gl[21:15] == 7'h0 ? 8'h00 : 8'h00, 4'b0100, ~gl[11:0]});
    check(intn, 1'b0);
    repeat (INT_PULSE_CYC + 10) @(negedge clk);
    check(intn, 1'b1);
    xfer(ADDR_GLOBAL_SETTINGS, 1'b1, {12'h000, gl[11:0]});
    // fault flag holds while present, clears on status read
    {fev, fpr} = 2'h3;
    repeat (6) @(negedge clk);
    fev = 1'b0;
    fm = 1'b1;
    xfer(ADDR_FAULT_STATUS, 1'b0, 24'h0);
    fpr = 1'b0;
    repeat (6) @(negedge clk);
    xfer(ADDR_FAULT_STATUS, 1'b0, 24'h0);
    xfer(ADDR_HIGH_IMPEDANCE, 1'b0, 24'h0);
    // overvoltage with and without the disable bit
    for (int k = 0; k < 2; k++)
    begin
      ov = 1'b1;
      repeat (6) @(negedge clk);
      check({lim, lpa}, {!gl[16], gl[16]});
      ov = 1'b0;
      xfer(ADDR_GLOBAL_SETTINGS, 1'b1, {2'b00, gl ^ 22'h010000});
    end
    // wake qualification on and off with the logic rail low
    for (int q = 1; q >= 0; q--)
    begin
      xfer(ADDR_GLOBAL_SETTINGS, 1'b1, {8'h00, q[0], 3'b000, gl[11:0]});
      low_power_mode = 1'b1;
      rail = 1'b0;
      repeat (6) @(negedge clk);
      n_wake = 0;
      waken = 1'b0;
      repeat (20) @(negedge clk);
      waken = 1'b1;
      check(n_wake, q);
      xfer(ADDR_HIGH_IMPEDANCE, 1'b1, {12'h000, ~hzm});
      {low_power_mode, rail} = 2'h1;
      repeat (6) @(negedge clk);
    end
    report_and_stop();
  end
endmodule // sic_config_regs_tb_top
bind sic_config_regs sic_cfg_sva sic_cfg_sva_i (.CLK_IN, .RESETN_IN, .CSN_IN, .OVERVOLTAGE_IN,
  .LOW_POWER_MODE_IN, .COMPARATOR_IN, .INTN_OUT, .WAKE_OUT, .LOW_POWER_ALLOWED_OUT, .CURRENT_LIMIT_2MA_OUT,
  .TO_BATTERY_SENSING_OUT, .HIGH_Z_OUT, .SOURCE_ENABLE_OUT, .COMPARATOR_ENABLE_OUT, .SWITCH_CLOSED_OUT);
`default_nettype wire
